/* include/encoder_regs_pkg.sv */
`default_nettype none
package encoder_regs_pkg;
  // Register byte addresses on the APB side
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_POS_LOW = 8'h04;
  localparam logic [7:0] OFS_POS_HIGH = 8'h08;
  localparam logic [7:0] OFS_POS_HOLD = 8'h0c;
  localparam logic [7:0] OFS_VEL_LOW = 8'h10;
  localparam logic [7:0] OFS_VEL_HIGH = 8'h14;
  localparam logic [7:0] OFS_VEL_HOLD = 8'h18;
  localparam logic [7:0] OFS_INT_LOW = 8'h1c;
  localparam logic [7:0] OFS_INT_HIGH = 8'h20;
  localparam logic [7:0] OFS_INT_HOLD_LOW = 8'h24;
  localparam logic [7:0] OFS_CONTROL = 8'h28;

  // Status register fields
  localparam int BIT_INDEX_IRQ_ENABLE = 0;
  localparam int BIT_INDEX_EVENT_FLAG = 1;
  localparam int BIT_HOME_IRQ_ENABLE = 2;
  localparam int BIT_HOME_EVENT_FLAG = 3;
  localparam int BIT_INIT_IRQ_ENABLE = 6;
  localparam int BIT_INIT_DONE_FLAG = 7;
  localparam logic [15:0] STATUS_ENABLE_MASK = 16'h0045;
  localparam logic [15:0] STATUS_FLAG_MASK = 16'h008a;

  // Control register fields
  localparam int CTRL_INIT_MODE_LSB = 0;
  localparam int INIT_MODE_W = 3;
  localparam logic [2:0] INIT_MODE_HOME_FIRST = 3'h3;
  localparam logic [2:0] INIT_MODE_HOME_SECOND = 3'h4;

  // Reset values
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] HOLD_RESET = 16'h0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [2:0] INIT_MODE_RESET = 3'h0;
endpackage : encoder_regs_pkg
`default_nettype wire

/* logic/split_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module split_counter #(
  parameter int WIDTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_value,
  input wire logic i_up,
  input wire logic i_down,
  output logic [WIDTH-1:0] o_value
);
  logic [WIDTH-1:0] value_d;
  logic [WIDTH-1:0] value_q;

  // A software load wins over a count strobe in the same cycle
  always_comb begin
    value_d = value_q;
    if (i_load) begin
      value_d = i_load_value;
    end else if (i_up && !i_down) begin
      value_d = value_q + WIDTH'(1);
    end else if (i_down && !i_up) begin
      value_d = value_q - WIDTH'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      value_q <= WIDTH'(0);
    end else begin
      value_q <= value_d;
    end
  end

  assign o_value = value_q;
endmodule : split_counter
`default_nettype wire

/* logic/encoder_status_counters.sv */
// Contract
// - Home event raises interrupt only while home interrupt enable bit 2 set.
// - Index event sets sticky flag bit 1; reads zero until an event.
// - Index event raises interrupt only while index interrupt enable bit 0 set.
// - Homing-init-done flag sets only in init modes 011 or 100.
// - Position counter 32 bits, low and high halves, read/write, reset zero.
// - 16-bit position hold register carries upper half for 32-bit access.
// - Velocity counter 32 bits, low and high halves, read/write, reset zero.
// - 16-bit velocity hold register carries upper half of velocity count.
// - Interval timer 32 bits, low and high halves, read/write, reset zero.
// - Interval hold register low half carries timer bits 15 to 0.
// - Home event sets sticky flag bit 3; reads zero until an event.
// - Flags set by hardware, cleared by software; enables plain read-write.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module encoder_status_counters #(
  parameter int COUNT_W = 32
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [encoder_regs_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_index_event,
  input wire logic i_home_event,
  input wire logic i_init_done,
  input wire logic i_pos_up,
  input wire logic i_pos_down,
  input wire logic i_vel_up,
  input wire logic i_vel_down,
  input wire logic i_interval_tick,
  output logic [COUNT_W-1:0] o_position_count,
  output logic [COUNT_W-1:0] o_velocity_count,
  output logic [encoder_regs_pkg::INIT_MODE_W-1:0] o_init_mode_select,
  output logic o_irq
);
  localparam int HALF_W = COUNT_W / 2;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_mapped(input logic [encoder_regs_pkg::ADDR_W-1:0] a);
    case (a)
      encoder_regs_pkg::OFS_STATUS, encoder_regs_pkg::OFS_POS_LOW,
      encoder_regs_pkg::OFS_POS_HIGH, encoder_regs_pkg::OFS_POS_HOLD,
      encoder_regs_pkg::OFS_VEL_LOW, encoder_regs_pkg::OFS_VEL_HIGH,
      encoder_regs_pkg::OFS_VEL_HOLD, encoder_regs_pkg::OFS_INT_LOW,
      encoder_regs_pkg::OFS_INT_HIGH, encoder_regs_pkg::OFS_INT_HOLD_LOW,
      encoder_regs_pkg::OFS_CONTROL: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  function automatic logic init_mode_ok(input logic [encoder_regs_pkg::INIT_MODE_W-1:0] m);
    init_mode_ok = (m == encoder_regs_pkg::INIT_MODE_HOME_FIRST) ||
                   (m == encoder_regs_pkg::INIT_MODE_HOME_SECOND);
  endfunction : init_mode_ok

  function automatic logic irq_pending(input logic [15:0] flags, input logic [15:0] en);
    // Each flag sits one bit above its enable
    irq_pending = |(flags & {en[14:0], 1'b0});
  endfunction : irq_pending

  ////////////////////////////////////////////////////////////////////////////
  logic access;
  logic wr_en;
  logic rd_en;
  logic pready_d, pready_q;
  logic pslverr_d, pslverr_q;
  logic [31:0] prdata_d, prdata_q;
  logic [15:0] wdata;
  logic [15:0] flags_d, flags_q;
  logic [15:0] enables_d, enables_q;
  logic [15:0] status_clr;
  logic irq_d, irq_q;
  logic [HALF_W-1:0] pos_hold_d, pos_hold_q;
  logic [HALF_W-1:0] vel_hold_d, vel_hold_q;
  logic [HALF_W-1:0] int_hold_d, int_hold_q;
  logic [encoder_regs_pkg::INIT_MODE_W-1:0] init_mode_d, init_mode_q;
  logic [COUNT_W-1:0] pos_value, vel_value, int_value;
  logic pos_load, vel_load, int_load;
  logic [COUNT_W-1:0] pos_load_value, vel_load_value, int_load_value;

  // Two-cycle access phase: pready registered so read side effects land on one edge
  assign access = i_psel && i_penable && !pready_q;
  assign wr_en = access && i_pwrite && addr_mapped(i_paddr);
  assign rd_en = access && !i_pwrite && addr_mapped(i_paddr);
  assign wdata = i_pwdata[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // APB answer
  always_comb begin
    pready_d = access;
    pslverr_d = access && !addr_mapped(i_paddr);
    prdata_d = prdata_q;
    if (access) begin
      prdata_d = 32'h0000_0000;
      if (!i_pwrite) begin
        case (i_paddr)
          encoder_regs_pkg::OFS_STATUS: prdata_d[15:0] = flags_q | enables_q;
          encoder_regs_pkg::OFS_POS_LOW: prdata_d[15:0] = pos_value[HALF_W-1:0];
          encoder_regs_pkg::OFS_POS_HIGH: prdata_d[15:0] = pos_value[COUNT_W-1:HALF_W];
          encoder_regs_pkg::OFS_POS_HOLD: prdata_d[15:0] = pos_hold_q;
          encoder_regs_pkg::OFS_VEL_LOW: prdata_d[15:0] = vel_value[HALF_W-1:0];
          encoder_regs_pkg::OFS_VEL_HIGH: prdata_d[15:0] = vel_value[COUNT_W-1:HALF_W];
          encoder_regs_pkg::OFS_VEL_HOLD: prdata_d[15:0] = vel_hold_q;
          encoder_regs_pkg::OFS_INT_LOW: prdata_d[15:0] = int_value[HALF_W-1:0];
          encoder_regs_pkg::OFS_INT_HIGH: prdata_d[15:0] = int_value[COUNT_W-1:HALF_W];
          encoder_regs_pkg::OFS_INT_HOLD_LOW: prdata_d[15:0] = int_hold_q;
          encoder_regs_pkg::OFS_CONTROL: prdata_d[2:0] = init_mode_q;
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, enables and interrupt
  assign status_clr = (wr_en && i_paddr == encoder_regs_pkg::OFS_STATUS) ?
                      (wdata & encoder_regs_pkg::STATUS_FLAG_MASK) : 16'h0000;

  always_comb begin
    enables_d = enables_q;
    init_mode_d = init_mode_q;
    if (wr_en && i_paddr == encoder_regs_pkg::OFS_STATUS) begin
      enables_d = wdata & encoder_regs_pkg::STATUS_ENABLE_MASK;
    end
    if (wr_en && i_paddr == encoder_regs_pkg::OFS_CONTROL) begin
      init_mode_d = wdata[encoder_regs_pkg::CTRL_INIT_MODE_LSB +: encoder_regs_pkg::INIT_MODE_W];
    end
    // Clear first, then set: an event in the clearing cycle survives
    flags_d = flags_q & ~status_clr;
    if (i_index_event) begin
      flags_d[encoder_regs_pkg::BIT_INDEX_EVENT_FLAG] = 1'b1;
    end
    if (i_home_event) begin
      flags_d[encoder_regs_pkg::BIT_HOME_EVENT_FLAG] = 1'b1;
    end
    if (i_init_done && init_mode_ok(init_mode_q)) begin
      flags_d[encoder_regs_pkg::BIT_INIT_DONE_FLAG] = 1'b1;
    end
    irq_d = irq_pending(flags_d, enables_d);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_q <= encoder_regs_pkg::STATUS_RESET;
      enables_q <= encoder_regs_pkg::STATUS_RESET;
      init_mode_q <= encoder_regs_pkg::INIT_MODE_RESET;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      enables_q <= enables_d;
      init_mode_q <= init_mode_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold registers and counter loads
  always_comb begin
    pos_hold_d = pos_hold_q;
    vel_hold_d = vel_hold_q;
    int_hold_d = int_hold_q;
    if (rd_en && i_paddr == encoder_regs_pkg::OFS_POS_LOW) begin
      pos_hold_d = pos_value[COUNT_W-1:HALF_W];
    end else if (wr_en && i_paddr == encoder_regs_pkg::OFS_POS_HOLD) begin
      pos_hold_d = wdata;
    end
    if (rd_en && i_paddr == encoder_regs_pkg::OFS_VEL_LOW) begin
      vel_hold_d = vel_value[COUNT_W-1:HALF_W];
    end else if (wr_en && i_paddr == encoder_regs_pkg::OFS_VEL_HOLD) begin
      vel_hold_d = wdata;
    end
    // Interval hold carries the low half, so the high half is the access key
    if (rd_en && i_paddr == encoder_regs_pkg::OFS_INT_HIGH) begin
      int_hold_d = int_value[HALF_W-1:0];
    end else if (wr_en && i_paddr == encoder_regs_pkg::OFS_INT_HOLD_LOW) begin
      int_hold_d = wdata;
    end
  end

  always_comb begin
    pos_load = wr_en && (i_paddr == encoder_regs_pkg::OFS_POS_LOW ||
                         i_paddr == encoder_regs_pkg::OFS_POS_HIGH);
    vel_load = wr_en && (i_paddr == encoder_regs_pkg::OFS_VEL_LOW ||
                         i_paddr == encoder_regs_pkg::OFS_VEL_HIGH);
    int_load = wr_en && (i_paddr == encoder_regs_pkg::OFS_INT_LOW ||
                         i_paddr == encoder_regs_pkg::OFS_INT_HIGH);
    pos_load_value = (i_paddr == encoder_regs_pkg::OFS_POS_LOW) ?
                     {pos_hold_q, wdata} : {wdata, pos_value[HALF_W-1:0]};
    vel_load_value = (i_paddr == encoder_regs_pkg::OFS_VEL_LOW) ?
                     {vel_hold_q, wdata} : {wdata, vel_value[HALF_W-1:0]};
    int_load_value = (i_paddr == encoder_regs_pkg::OFS_INT_HIGH) ?
                     {wdata, int_hold_q} : {int_value[COUNT_W-1:HALF_W], wdata};
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos_hold_q <= encoder_regs_pkg::HOLD_RESET;
      vel_hold_q <= encoder_regs_pkg::HOLD_RESET;
      int_hold_q <= encoder_regs_pkg::HOLD_RESET;
    end else begin
      pos_hold_q <= pos_hold_d;
      vel_hold_q <= vel_hold_d;
      int_hold_q <= int_hold_d;
    end
  end

  split_counter #(.WIDTH(COUNT_W)) u_position (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_load(pos_load),
    .i_load_value(pos_load_value),
    .i_up(i_pos_up),
    .i_down(i_pos_down),
    .o_value(pos_value)
  );

  split_counter #(.WIDTH(COUNT_W)) u_velocity (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_load(vel_load),
    .i_load_value(vel_load_value),
    .i_up(i_vel_up),
    .i_down(i_vel_down),
    .o_value(vel_value)
  );

  // Interval timer only counts up; a wrap is left to software
  split_counter #(.WIDTH(COUNT_W)) u_interval (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_load(int_load),
    .i_load_value(int_load_value),
    .i_up(i_interval_tick),
    .i_down(1'b0),
    .o_value(int_value)
  );

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_irq = irq_q;
  assign o_position_count = pos_value;
  assign o_velocity_count = vel_value;
  assign o_init_mode_select = init_mode_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_index_flag_set: assert property (i_index_event |=> flags_q[1])
    else $error("index flag not set after index event");
  a_index_flag_sticky: assert property (flags_q[1] && !status_clr[1] |=> flags_q[1])
    else $error("index flag dropped without software clear");
  a_home_flag_set: assert property (i_home_event |=> flags_q[3])
    else $error("home flag not set after home event");
  a_flag_hw_only: assert property ($rose(flags_q[3]) |-> $past(i_home_event))
    else $error("home flag set without home event");
  a_home_irq: assert property (flags_q[3] && enables_q[2] |-> o_irq)
    else $error("enabled home flag without interrupt");
  a_index_irq: assert property (flags_q[1] && enables_q[0] |-> o_irq)
    else $error("enabled index flag without interrupt");
  a_no_masked_irq: assert property (o_irq |-> (flags_q[1] && enables_q[0]) ||
      (flags_q[3] && enables_q[2]) || (flags_q[7] && enables_q[6]))
    else $error("interrupt without an enabled flag");
  a_init_mode_gate: assert property ($rose(flags_q[7]) |-> init_mode_ok($past(init_mode_q)))
    else $error("init done flag set outside modes 3 and 4");
  a_pos_low_write: assert property (
      wr_en && i_paddr == encoder_regs_pkg::OFS_POS_LOW |=>
      pos_value == {$past(pos_hold_q), $past(wdata)})
    else $error("position low write did not load full value");
  a_pos_hold_latch: assert property (
      rd_en && i_paddr == encoder_regs_pkg::OFS_POS_LOW |=>
      pos_hold_q == $past(pos_value[COUNT_W-1:HALF_W]))
    else $error("position hold not latched on low read");
  a_vel_hold_latch: assert property (
      rd_en && i_paddr == encoder_regs_pkg::OFS_VEL_LOW |=>
      vel_hold_q == $past(vel_value[COUNT_W-1:HALF_W]))
    else $error("velocity hold not latched on low read");
  a_int_high_write: assert property (
      wr_en && i_paddr == encoder_regs_pkg::OFS_INT_HIGH |=>
      int_value == {$past(wdata), $past(int_hold_q)})
    else $error("interval high write did not use hold");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");
  a_index_hw_only: assert property ($rose(flags_q[1]) |-> $past(i_index_event))
    else $error("index flag set without index event");
  a_home_flag_sticky: assert property (flags_q[3] && !status_clr[3] |=> flags_q[3])
    else $error("home flag dropped without software clear");
  a_enable_plain_rw: assert property (
      wr_en && i_paddr == encoder_regs_pkg::OFS_STATUS |=>
      enables_q == $past(wdata & encoder_regs_pkg::STATUS_ENABLE_MASK))
    else $error("enable bits did not follow status write");
  a_pos_high_write: assert property (
      wr_en && i_paddr == encoder_regs_pkg::OFS_POS_HIGH |=>
      pos_value == {$past(wdata), $past(pos_value[HALF_W-1:0])})
    else $error("position high write disturbed low half");
  a_vel_low_write: assert property (
      wr_en && i_paddr == encoder_regs_pkg::OFS_VEL_LOW |=>
      vel_value == {$past(vel_hold_q), $past(wdata)})
    else $error("velocity low write did not load full value");
  a_int_hold_latch: assert property (
      rd_en && i_paddr == encoder_regs_pkg::OFS_INT_HIGH |=>
      int_hold_q == $past(int_value[HALF_W-1:0]))
    else $error("interval hold not latched on high read");
  a_int_low_write: assert property (
      wr_en && i_paddr == encoder_regs_pkg::OFS_INT_LOW |=>
      int_value == {$past(int_value[COUNT_W-1:HALF_W]), $past(wdata)})
    else $error("interval low write disturbed high half");

  // Strobes move a counter only when no software load lands in that cycle
  a_pos_count_up: assert property (
      !pos_load && i_pos_up && !i_pos_down |=>
      pos_value == $past(pos_value) + COUNT_W'(1))
    else $error("position did not count up");
  a_vel_count_down: assert property (
      !vel_load && i_vel_down && !i_vel_up |=>
      vel_value == $past(vel_value) - COUNT_W'(1))
    else $error("velocity did not count down");
  a_int_tick_count: assert property (
      !int_load && i_interval_tick |=>
      int_value == $past(int_value) + COUNT_W'(1))
    else $error("interval timer did not advance on tick");
  a_slverr_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("slave error outside a completing transfer");
  a_prdata_upper_zero: assert property (o_pready |-> o_prdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");

  c_index_irq: cover property (i_index_event && enables_q[0] ##1 o_irq);
  c_pos_split_read: cover property (rd_en && i_paddr == encoder_regs_pkg::OFS_POS_LOW);
  c_set_and_clear: cover property (i_home_event && status_clr[3]);
  c_init_done: cover property ($rose(flags_q[7]));
  c_int_split_read: cover property (rd_en && i_paddr == encoder_regs_pkg::OFS_INT_HIGH);
endmodule : encoder_status_counters
`default_nettype wire

/* test/encoder_model.sv */
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_req,
  output logic o_index_event,
  output logic o_home_event,
  output logic o_init_done,
  output logic o_pos_up,
  output logic o_pos_down,
  output logic o_vel_up,
  output logic o_vel_down,
  output logic o_interval_tick
);
  logic [7:0] req_q;
  ////////////////////////////////////////////////////////////////
  // Registered so every strobe is a clean same-clock pulse
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_q <= 8'h00;
    end else begin
      req_q <= i_req;
    end
  end
  assign o_index_event = req_q[0];
  assign o_home_event = req_q[1];
  assign o_init_done = req_q[2];
  assign o_pos_up = req_q[3];
  assign o_pos_down = req_q[4];
  assign o_vel_up = req_q[5];
  assign o_vel_down = req_q[6];
  assign o_interval_tick = req_q[7];
endmodule : encoder_model
`default_nettype wire

/* test/quadrature_counter_status_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module quadrature_counter_status_regs_test;
  logic i_clk;
  logic i_rstn;
  logic psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr, req;
  logic [31:0] pwdata, prdata, rd, pos_cnt, vel_cnt, v, ex;
  logic [15:0] hv, kv, w;
  logic [2:0] mode;
  logic ev_i, ev_h, ev_n, pu, pd, vu, vd, tk, u, d;
  logic [7:0] key_a [3];
  logic [7:0] hold_a [3];
  logic [7:0] oth_a [3];
  int num_errors, compares, eb, fb, n;
  localparam logic [7:0] ST = encoder_regs_pkg::OFS_STATUS;
  encoder_model u_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req),
    .o_index_event(ev_i), .o_home_event(ev_h), .o_init_done(ev_n), .o_pos_up(pu),
    .o_pos_down(pd), .o_vel_up(vu), .o_vel_down(vd), .o_interval_tick(tk));
  encoder_status_counters u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_index_event(ev_i),
    .i_home_event(ev_h), .i_init_done(ev_n), .i_pos_up(pu), .i_pos_down(pd),
    .i_vel_up(vu), .i_vel_down(vd), .i_interval_tick(tk), .o_position_count(pos_cnt),
    .o_velocity_count(vel_cnt), .o_init_mode_select(mode), .o_irq(irq));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Extra idle edge at the end so psel is never reassigned in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge i_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge i_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask : apb
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask : rchk
  task automatic pulse(input int b);
    req[b] <= 1'b1;
    @(posedge i_clk);
    req[b] <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : pulse
  ////////////////////////////////////////////////////////////////
  initial begin
    key_a = '{encoder_regs_pkg::OFS_POS_LOW, encoder_regs_pkg::OFS_VEL_LOW,
      encoder_regs_pkg::OFS_INT_HIGH};
    hold_a = '{encoder_regs_pkg::OFS_POS_HOLD, encoder_regs_pkg::OFS_VEL_HOLD,
      encoder_regs_pkg::OFS_INT_HOLD_LOW};
    oth_a = '{encoder_regs_pkg::OFS_POS_HIGH, encoder_regs_pkg::OFS_VEL_HIGH,
      encoder_regs_pkg::OFS_INT_LOW};
    {psel, penable, pwrite, paddr, pwdata, req} = '0;
    i_rstn = 1'b0;
    num_errors = 0;
    compares = 0;
    void'($urandom(32'hba6a));
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a <= 40; a += 4) begin
      rchk("reset", 8'(a), 32'h0);
    end
    rchk("unmapped", 8'h2c, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    apb(1'b1, ST, 32'h0000_ffff);
    rchk("sw set", ST, {16'h0, encoder_regs_pkg::STATUS_ENABLE_MASK});
    apb(1'b1, ST, 32'h0);
    for (int k = 0; k < 2; k++) begin
      eb = k ? encoder_regs_pkg::BIT_HOME_IRQ_ENABLE : encoder_regs_pkg::BIT_INDEX_IRQ_ENABLE;
      fb = k ? encoder_regs_pkg::BIT_HOME_EVENT_FLAG : encoder_regs_pkg::BIT_INDEX_EVENT_FLAG;
      pulse(k);
      rchk("flag", ST, 32'h1 << fb);
      check("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b1, ST, 32'h1 << eb);
      check("irq on", {31'h0, irq}, 32'h1);
      apb(1'b1, ST, (32'h1 << eb) | (32'h1 << fb));
      rchk("cleared", ST, 32'h1 << eb);
      check("irq off", {31'h0, irq}, 32'h0);
      pulse(k);
      check("irq event", {31'h0, irq}, 32'h1);
      apb(1'b1, ST, 32'h1 << fb);
      rchk("idle", ST, 32'h0);
    end
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, encoder_regs_pkg::OFS_CONTROL, 32'(m));
      check("mode", {29'h0, mode}, 32'(m));
      pulse(2);
      rchk("init", ST, (m == 3 || m == 4) ? 32'h80 : 32'h0);
      apb(1'b1, ST, 32'h1 << encoder_regs_pkg::BIT_INIT_DONE_FLAG);
    end
    // Event and clear land on one edge: the hardware set must survive
    fork
      apb(1'b1, ST, 32'h1 << encoder_regs_pkg::BIT_HOME_EVENT_FLAG);
      pulse(1);
    join
    rchk("set wins", ST, 32'h8);
    apb(1'b1, ST, 32'h8);
    // Pos and vel key on low half; interval keys on high half
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 4; j++) begin
        v = (j == 0) ? 32'hffff_ffff : $urandom;
        hv = (k == 2) ? v[15:0] : v[31:16];
        kv = (k == 2) ? v[31:16] : v[15:0];
        apb(1'b1, hold_a[k], {16'h0, hv});
        apb(1'b1, key_a[k], {16'h0, kv});
        ex = v;
        n = $urandom_range(20, 1);
        for (int i = 0; i < n; i++) begin
          u = 1'($urandom);
          d = (k < 2) ? 1'($urandom) : 1'b0;
          req[3 + 2 * k] <= u;
          if (k < 2) req[4 + 2 * k] <= d;
          if (u && !d) ex = ex + 32'h1;
          if (d && !u) ex = ex - 32'h1;
          @(posedge i_clk);
        end
        req <= 8'h00;
        repeat (3) @(posedge i_clk);
        if (k < 2) check("count", (k == 0) ? pos_cnt : vel_cnt, ex);
        rchk("key", key_a[k], {16'h0, (k == 2) ? ex[31:16] : ex[15:0]});
        rchk("hold", hold_a[k], {16'h0, (k == 2) ? ex[15:0] : ex[31:16]});
        rchk("other", oth_a[k], {16'h0, (k == 2) ? ex[15:0] : ex[31:16]});
        w = 16'($urandom);
        apb(1'b1, oth_a[k], {16'h0, w});
        // Key half is untouched; its read latches the freshly written other half
        rchk("key2", key_a[k], {16'h0, (k == 2) ? ex[31:16] : ex[15:0]});
        rchk("hold2", hold_a[k], {16'h0, w});
      end
    end
    // Second reset after activity: counters and holds go back to zero
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    check("reset pos", pos_cnt, 32'h0);
    check("reset vel", vel_cnt, 32'h0);
    rchk("reset vel hold", encoder_regs_pkg::OFS_VEL_HOLD, 32'h0);
    rchk("reset int", encoder_regs_pkg::OFS_INT_HIGH, 32'h0);
    test_done();
  end
endmodule : quadrature_counter_status_regs_test
`default_nettype wire
